// *** core/hsr_chan.sv ***
`timescale 1ns/1ps
module hsr_chan
   import hsr_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Control
   input  wire logic active,
   // Comparator levels, already synchronised
   input  wire logic a_low,
   input  wire logic b_strong_low,
   input  wire logic b_weak_low,
   // Pull-down requests
   output logic      drive_a,
   output logic      drive_b
);
   hsr_chan_t           st;
   hsr_chan_t           next_st;
   logic [ECHO_CYC-1:0] a_echo;
   logic [ECHO_CYC-1:0] b_echo;
   logic [ECHO_CYC-1:0] next_a_echo;
   logic [ECHO_CYC-1:0] next_b_echo;
   logic                a_own;
   logic                b_own;

   // Own pull-downs come back through the pin flop and the synchroniser;
   // without this mask a released line would be read as an outside LOW
   assign a_own = |a_echo;
   assign b_own = |b_echo;

   always_comb begin
      next_st     = st;
      next_a_echo = {a_echo[ECHO_CYC-2:0], drive_a};
      next_b_echo = {b_echo[ECHO_CYC-2:0], drive_b};
      if (!active) begin
         next_st = HSR_CH_IDLE;
      end else begin
         case (st)
            HSR_CH_IDLE: begin
               // A side wins a simultaneous fall: it is the zero-offset side
               if (a_low) begin
                  next_st = HSR_CH_A2B;
               end else if (b_strong_low) begin
                  next_st = HSR_CH_B2A;
               end else if (b_weak_low && !b_own) begin
                  next_st = HSR_CH_WEAK;
               end
            end
            HSR_CH_A2B: if (!a_low) next_st = HSR_CH_IDLE;
            // Own offset is invisible to b_strong_low, so no lock-up
            HSR_CH_B2A: if (!b_strong_low) next_st = HSR_CH_PLAT;
            HSR_CH_WEAK: begin
               if (b_strong_low) next_st = HSR_CH_B2A;
               else next_st = HSR_CH_PLAT;
            end
            HSR_CH_PLAT: if (!a_low && !a_own) next_st = HSR_CH_IDLE;
            default: next_st = HSR_CH_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st     <= HSR_CH_IDLE;
         a_echo <= '0;
         b_echo <= '0;
      end else begin
         st     <= next_st;
         a_echo <= next_a_echo;
         b_echo <= next_b_echo;
      end
   end

   assign drive_a = (st == HSR_CH_B2A) || (st == HSR_CH_WEAK);
   assign drive_b = (st == HSR_CH_A2B) || (st == HSR_CH_B2A) ||
                    (st == HSR_CH_WEAK) || (st == HSR_CH_PLAT);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_b_released;
      active && st == HSR_CH_B2A && !b_strong_low;
   endsequence
   sequence s_plateau;
      !drive_a && drive_b;
   endsequence

   chk_a_to_b: assert property (
      (active && st == HSR_CH_IDLE && a_low) |=> drive_b && !drive_a)
      else $error("A low did not pull B down");
   chk_b_off: assert property (
      (active && st == HSR_CH_A2B && !a_low) |=> !drive_b)
      else $error("B pull-down stayed on after A rose");
   chk_b_to_a: assert property (
      (active && st == HSR_CH_IDLE && !a_low && b_strong_low) |=> drive_a)
      else $error("B low did not pull A down");
   chk_b_plateau: assert property (
      s_b_released |=> s_plateau)
      else $error("B plateau missing after B release");
   chk_weak_glitch: assert property (
      (active && st == HSR_CH_IDLE && !a_low && !b_strong_low && b_weak_low && !b_own)
      |=> drive_a and ((!b_strong_low && active) |=> s_plateau))
      else $error("Weak B low sequence wrong");
   chk_idle_off: assert property (
      !active |=> !drive_a && !drive_b)
      else $error("Channel drives while inactive");
   chk_own_echo: assert property (
      (active && st == HSR_CH_IDLE && !a_low && !b_strong_low && b_own) |=> st == HSR_CH_IDLE)
      else $error("Own B offset taken as an outside LOW");
   chk_plat_hold: assert property (
      (active && st == HSR_CH_PLAT && a_own) |=> drive_b)
      else $error("B plateau dropped before A rose");

endmodule // hsr_chan

// *** core/hsr_idle_det.sv ***
`timescale 1ns/1ps
module hsr_idle_det
   import hsr_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Armed after initialization
   input  wire logic armed,
   // Line levels, HIGH means released
   input  wire logic a_clk_hi,
   input  wire logic a_dat_hi,
   input  wire logic b_clk_hi,
   input  wire logic b_dat_hi,
   // Connection may be made
   output logic      bus_free
);
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             prev_a_clk;
   logic             prev_a_dat;
   logic             all_hi;
   logic             stop_seen;

   assign all_hi    = a_clk_hi && a_dat_hi && b_clk_hi && b_dat_hi;
   // Data rising while clock stays high
   assign stop_seen = armed && all_hi && prev_a_clk && !prev_a_dat;

   always_comb begin
      next_cnt = cnt;
      if (!armed || !all_hi) begin
         next_cnt = CNT_ZERO;
      end else if (cnt != IDLE_LAST) begin
         next_cnt = cnt + CNT_ONE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt        <= CNT_ZERO;
         prev_a_clk <= 1'b1;
         prev_a_dat <= 1'b1;
      end else begin
         cnt        <= next_cnt;
         prev_a_clk <= a_clk_hi;
         prev_a_dat <= a_dat_hi;
      end
   end

   assign bus_free = stop_seen || (armed && all_hi && cnt == IDLE_LAST);

   chk_idle_clear: assert property (
      @(posedge clk) disable iff (!arst_n) (!all_hi) |=> cnt == CNT_ZERO)
      else $error("Idle count not cleared by a low line");

endmodule // hsr_idle_det

// *** core/hsr_pkg.sv ***
// Function
// - Keep every pull-down off until both supplies report good, any order.
// - Power-up holds the disconnected state with all four lines released.
// - Enable LOW forces the disconnected state and stops all propagation.
// - Power good with enable HIGH enters initialization, then arms the detector.
// - Connect after initialization on bus idle time or an A-side STOP.
// - Enabled on a busy bus, connect at first STOP or idle gap.
// - Connected, A line LOW switches on the matching B pull-down.
// - A line back HIGH switches the matching B pull-down off.
// - Connected, B line strongly LOW switches on the matching A pull-down.
// - B line released to the offset level switches the A pull-down off.
// - B pull-down holds its offset until the A line rises again.
// - Weak B LOW pulses the A pull-down, then releases B after A rises.
// - Enable is active HIGH and defaults HIGH when nothing drives it.
// - The repeater's own B offset LOW is never taken as a LOW.
package hsr_pkg;

   localparam int REF_CLK_PERIOD_NS = 20;
   // Settle and idle times are plain defaults
   localparam int INIT_SETTLE_NS    = 1000;
   localparam int BUS_IDLE_NS       = 40000;
   // Least times round up to whole cycles
   localparam int INIT_CYC = (INIT_SETTLE_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
   localparam int IDLE_CYC = (BUS_IDLE_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

   localparam int               CNT_W     = 12;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE   = 12'h001;
   localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYC - 1);
   localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYC - 1);

   // Synchroniser bit positions
   localparam int SYN_W       = 9;
   localparam int SYN_VCCA    = 0;
   localparam int SYN_VCCB    = 1;
   localparam int SYN_EN      = 2;
   localparam int SYN_A_CLK   = 3;
   localparam int SYN_A_DAT   = 4;
   localparam int SYN_B_CLK   = 5;
   localparam int SYN_B_DAT   = 6;
   localparam int SYN_B_CLK_M = 7;
   localparam int SYN_B_DAT_M = 8;
   // Supplies start bad, enable and lines start HIGH
   localparam logic [SYN_W-1:0] SYN_RST = 9'h1FC;
   // Own pull-down reaches the comparators again after OE flop plus two sync flops
   localparam int ECHO_CYC = 3;

   typedef enum logic [1:0] {
      HSR_DISC = 2'b00,
      HSR_INIT = 2'b01,
      HSR_WAIT = 2'b11,
      HSR_CONN = 2'b10
   } hsr_link_t;

   typedef enum logic [2:0] {
      HSR_CH_IDLE = 3'b000,
      HSR_CH_WEAK = 3'b001,
      HSR_CH_B2A  = 3'b011,
      HSR_CH_PLAT = 3'b010,
      HSR_CH_A2B  = 3'b100
   } hsr_chan_t;

endpackage

// *** core/hsr_top.sv ***
`timescale 1ns/1ps
module hsr_top
   import hsr_pkg::*;
(
   // Clock and reset
   input  wire logic REF_CLK,
   input  wire logic ARST_N,
   // Supply monitors and enable pin
   input  wire logic VCCA_GOOD,
   input  wire logic VCCB_GOOD,
   input  wire logic EN_PIN,
   // A-side clock line, HIGH above half the A supply
   input  wire logic LOW_SIDE_CLOCK_LINE_IN,
   output logic      LOW_SIDE_CLOCK_LINE_OUT,
   output logic      LOW_SIDE_CLOCK_LINE_OE,
   // A-side data line
   input  wire logic LOW_SIDE_DATA_LINE_IN,
   output logic      LOW_SIDE_DATA_LINE_OUT,
   output logic      LOW_SIDE_DATA_LINE_OE,
   // B-side clock line: IN is contention level, MID_IN is 30 percent level
   input  wire logic HIGH_SIDE_CLOCK_LINE_IN,
   input  wire logic HIGH_SIDE_CLOCK_LINE_MID_IN,
   output logic      HIGH_SIDE_CLOCK_LINE_OUT,
   output logic      HIGH_SIDE_CLOCK_LINE_OE,
   // B-side data line
   input  wire logic HIGH_SIDE_DATA_LINE_IN,
   input  wire logic HIGH_SIDE_DATA_LINE_MID_IN,
   output logic      HIGH_SIDE_DATA_LINE_OUT,
   output logic      HIGH_SIDE_DATA_LINE_OE,
   // Link status
   output logic      CONNECTED
);
   logic [SYN_W-1:0] syn_meta;
   logic [SYN_W-1:0] syn;
   logic [SYN_W-1:0] pin_raw;

   hsr_link_t        state;
   hsr_link_t        next_state;
   logic [CNT_W-1:0] init_cnt;
   logic [CNT_W-1:0] next_init_cnt;

   logic             pwr_good;
   logic             en_s;
   logic             run;
   logic             armed;
   logic             bus_free;
   logic             active;

   logic             clk_drive_a;
   logic             clk_drive_b;
   logic             dat_drive_a;
   logic             dat_drive_b;

   logic             a_clk_oe;
   logic             a_dat_oe;
   logic             b_clk_oe;
   logic             b_dat_oe;
   logic             line_out;
   logic             conn_q;
   logic             next_a_clk_oe;
   logic             next_a_dat_oe;
   logic             next_b_clk_oe;
   logic             next_b_dat_oe;
   logic             next_conn_q;

   // Assertion helpers
   logic             lines_hi;
   logic [CNT_W-1:0] quiet_run;
   logic [CNT_W-1:0] next_quiet_run;

   // Every pull-down request passes the same connection gate
   function automatic logic oe_gate(input logic conn, input logic act, input logic drive);
      return conn && act && drive;
   endfunction

   // Every pin input is asynchronous to REF_CLK
   always_comb begin
      pin_raw              = '0;
      pin_raw[SYN_VCCA]    = VCCA_GOOD;
      pin_raw[SYN_VCCB]    = VCCB_GOOD;
      pin_raw[SYN_EN]      = EN_PIN;
      pin_raw[SYN_A_CLK]   = LOW_SIDE_CLOCK_LINE_IN;
      pin_raw[SYN_A_DAT]   = LOW_SIDE_DATA_LINE_IN;
      pin_raw[SYN_B_CLK]   = HIGH_SIDE_CLOCK_LINE_IN;
      pin_raw[SYN_B_DAT]   = HIGH_SIDE_DATA_LINE_IN;
      pin_raw[SYN_B_CLK_M] = HIGH_SIDE_CLOCK_LINE_MID_IN;
      pin_raw[SYN_B_DAT_M] = HIGH_SIDE_DATA_LINE_MID_IN;
   end

   // Enable resets HIGH, as its pull-up would leave it
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         syn_meta <= SYN_RST;
         syn      <= SYN_RST;
      end else begin
         syn_meta <= pin_raw;
         syn      <= syn_meta;
      end
   end

   // Either supply may come up first; only both together count
   assign pwr_good = syn[SYN_VCCA] && syn[SYN_VCCB];
   assign en_s     = syn[SYN_EN];
   assign run      = pwr_good && en_s;
   assign armed    = (state == HSR_WAIT);
   assign active   = (state == HSR_CONN);

   always_comb begin
      next_state    = state;
      next_init_cnt = CNT_ZERO;
      if (!run) begin
         next_state = HSR_DISC;
      end else begin
         case (state)
            HSR_DISC: next_state = HSR_INIT;
            HSR_INIT: begin
               if (init_cnt == INIT_LAST) begin
                  next_state = HSR_WAIT;
               end else begin
                  next_init_cnt = init_cnt + CNT_ONE;
               end
            end
            // Waiting on a busy bus: first STOP or idle gap wins
            HSR_WAIT: if (bus_free) next_state = HSR_CONN;
            HSR_CONN: next_state = HSR_CONN;
            default:  next_state = HSR_DISC;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state    <= HSR_DISC;
         init_cnt <= CNT_ZERO;
      end else begin
         state    <= next_state;
         init_cnt <= next_init_cnt;
      end
   end

   hsr_idle_det u_idle (
      .clk      (REF_CLK),
      .arst_n   (ARST_N),
      .armed    (armed),
      .a_clk_hi (syn[SYN_A_CLK]),
      .a_dat_hi (syn[SYN_A_DAT]),
      .b_clk_hi (syn[SYN_B_CLK_M]),
      .b_dat_hi (syn[SYN_B_DAT_M]),
      .bus_free (bus_free)
   );

   hsr_chan u_clk (
      .clk          (REF_CLK),
      .arst_n       (ARST_N),
      .active       (active),
      .a_low        (!syn[SYN_A_CLK]),
      .b_strong_low (!syn[SYN_B_CLK]),
      .b_weak_low   (!syn[SYN_B_CLK_M]),
      .drive_a      (clk_drive_a),
      .drive_b      (clk_drive_b)
   );

   hsr_chan u_dat (
      .clk          (REF_CLK),
      .arst_n       (ARST_N),
      .active       (active),
      .a_low        (!syn[SYN_A_DAT]),
      .b_strong_low (!syn[SYN_B_DAT]),
      .b_weak_low   (!syn[SYN_B_DAT_M]),
      .drive_a      (dat_drive_a),
      .drive_b      (dat_drive_b)
   );

   // Gating on the next state drops drivers the cycle power or enable falls
   always_comb begin
      next_conn_q   = (next_state == HSR_CONN);
      next_a_clk_oe = oe_gate(next_conn_q, active, clk_drive_a);
      next_a_dat_oe = oe_gate(next_conn_q, active, dat_drive_a);
      next_b_clk_oe = oe_gate(next_conn_q, active, clk_drive_b);
      next_b_dat_oe = oe_gate(next_conn_q, active, dat_drive_b);
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         a_clk_oe <= 1'b0;
         a_dat_oe <= 1'b0;
         b_clk_oe <= 1'b0;
         b_dat_oe <= 1'b0;
         conn_q   <= 1'b0;
         line_out <= 1'b0;
      end else begin
         a_clk_oe <= next_a_clk_oe;
         a_dat_oe <= next_a_dat_oe;
         b_clk_oe <= next_b_clk_oe;
         b_dat_oe <= next_b_dat_oe;
         conn_q   <= next_conn_q;
         line_out <= 1'b0;
      end
   end

   // Open-drain: the pins only ever pull LOW
   assign LOW_SIDE_CLOCK_LINE_OUT  = line_out;
   assign LOW_SIDE_DATA_LINE_OUT   = line_out;
   assign HIGH_SIDE_CLOCK_LINE_OUT = line_out;
   assign HIGH_SIDE_DATA_LINE_OUT  = line_out;
   assign LOW_SIDE_CLOCK_LINE_OE   = a_clk_oe;
   assign LOW_SIDE_DATA_LINE_OE    = a_dat_oe;
   assign HIGH_SIDE_CLOCK_LINE_OE  = b_clk_oe;
   assign HIGH_SIDE_DATA_LINE_OE   = b_dat_oe;
   assign CONNECTED                = conn_q;

   // Independent count of all-high cycles while waiting, for the idle bound
   assign lines_hi = syn[SYN_A_CLK] && syn[SYN_A_DAT] && syn[SYN_B_CLK_M] && syn[SYN_B_DAT_M];

   always_comb begin
      next_quiet_run = CNT_ZERO;
      if (armed && lines_hi) begin
         next_quiet_run = (quiet_run == IDLE_LAST) ? quiet_run : quiet_run + CNT_ONE;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         quiet_run <= CNT_ZERO;
      end else begin
         quiet_run <= next_quiet_run;
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_init_start;
      state == HSR_DISC && run;
   endsequence
   sequence s_no_oe;
      !a_clk_oe && !a_dat_oe && !b_clk_oe && !b_dat_oe;
   endsequence

   chk_supply_gate: assert property (
      !pwr_good |=> (state == HSR_DISC) ##0 s_no_oe)
      else $error("Drivers active without both supplies good");
   chk_disc_release: assert property (
      (state != HSR_CONN) |-> s_no_oe)
      else $error("Line driven while not connected");
   chk_enable_low: assert property (
      !en_s |=> state == HSR_DISC && !CONNECTED)
      else $error("Enable low did not disconnect");
   chk_init_entry: assert property (
      s_init_start |=> state == HSR_INIT && init_cnt == CNT_ZERO)
      else $error("Initialization not entered");
   chk_init_hold: assert property (
      (state == HSR_INIT && init_cnt != INIT_LAST && run) |=> state == HSR_INIT)
      else $error("Initialization ended early");
   chk_init_done: assert property (
      (state == HSR_INIT && init_cnt == INIT_LAST && run) |=> state == HSR_WAIT)
      else $error("Initialization did not arm detector");
   chk_no_early_conn: assert property (
      (state == HSR_WAIT && !bus_free) |=> state != HSR_CONN)
      else $error("Connected without STOP or idle");
   chk_conn_on_free: assert property (
      (state == HSR_WAIT && bus_free && run) |=> state == HSR_CONN && CONNECTED)
      else $error("Free bus did not connect");
   chk_b_follows_a: assert property (
      (active && $past(active) && clk_drive_b && next_conn_q) |=> HIGH_SIDE_CLOCK_LINE_OE)
      else $error("B clock pull-down not driven");

   // Pin-level followers and link bounds
   chk_dat_follows: assert property (
      (active && dat_drive_b && next_conn_q) |=> HIGH_SIDE_DATA_LINE_OE)
      else $error("B data pull-down not driven");
   chk_clk_release: assert property (
      (active && !clk_drive_b && next_conn_q) |=> !HIGH_SIDE_CLOCK_LINE_OE)
      else $error("B clock pull-down not released");
   chk_a_clk_follows: assert property (
      (active && clk_drive_a && next_conn_q) |=> LOW_SIDE_CLOCK_LINE_OE)
      else $error("A clock pull-down not driven");
   chk_a_dat_follows: assert property (
      (active && dat_drive_a && next_conn_q) |=> LOW_SIDE_DATA_LINE_OE)
      else $error("A data pull-down not driven");
   chk_drop_release: assert property (
      !run |=> s_no_oe ##0 !CONNECTED)
      else $error("Power or enable drop left a line driven");
   chk_open_drain: assert property (
      !LOW_SIDE_CLOCK_LINE_OUT && !LOW_SIDE_DATA_LINE_OUT &&
      !HIGH_SIDE_CLOCK_LINE_OUT && !HIGH_SIDE_DATA_LINE_OUT)
      else $error("Pin output driven HIGH");
   chk_conn_stays: assert property (
      (state == HSR_CONN && run) |=> state == HSR_CONN)
      else $error("Connection lost while powered and enabled");
   chk_idle_bound: assert property (
      (armed && run && lines_hi && quiet_run == IDLE_LAST) |=> state == HSR_CONN)
      else $error("Idle bus did not connect in time");
   chk_stop_connect: assert property (
      (armed && run && lines_hi && $past(syn[SYN_A_CLK]) && !$past(syn[SYN_A_DAT]))
      |=> state == HSR_CONN)
      else $error("A-side STOP did not connect");
   chk_wait_busy: assert property (
      (armed && !lines_hi) |=> state != HSR_CONN)
      else $error("Connected while a line was low");
   chk_init_count: assert property (
      (state == HSR_INIT) |-> init_cnt <= INIT_LAST)
      else $error("Settle count ran past its end");

endmodule // hsr_top

// *** verif/hsr_bus_model.sv ***
`timescale 1ns/1ps
module hsr_bus_model (
   // Repeater pull-downs, index 0 clock, index 1 data
   input  wire logic [1:0] a_oe,
   input  wire logic [1:0] b_oe,
   // Outside devices
   input  wire logic [1:0] ext_a_low,
   input  wire logic [1:0] ext_b_strong,
   input  wire logic [1:0] ext_b_weak,
   // Enable pin driver, released while en_drive is low
   input  wire logic       en_drive,
   input  wire logic       en_level,
   // Comparator levels seen by the repeater
   output logic [1:0]      a_in,
   output logic [1:0]      b_in,
   output logic [1:0]      b_mid,
   output logic            en_pin
);
   // Each line has its own pull-up, so it is HIGH unless someone sinks it
   assign a_in   = ~(a_oe | ext_a_low);
   // Only a strong outside driver gets under the contention level; the
   // repeater's own offset LOW and a weak driver stay above it
   assign b_in   = ~ext_b_strong;
   assign b_mid  = ~(b_oe | ext_b_strong | ext_b_weak);
   // An undriven enable pin floats HIGH
   assign en_pin = en_drive ? en_level : 1'b1;
endmodule // hsr_bus_model

// *** verif/hsr_top_tb.sv ***
`timescale 1ns/1ps
module hsr_top_tb;
   import hsr_pkg::*;

   logic       clk;
   logic       arst_n;
   logic       vcca;
   logic       vccb;
   logic       en_drive;
   logic       en_level;
   logic       en_pin;
   logic [1:0] ext_a;
   logic [1:0] ext_bs;
   logic [1:0] ext_bw;
   logic [1:0] a_in;
   logic [1:0] b_in;
   logic [1:0] b_mid;
   logic [1:0] a_oe;
   logic [1:0] b_oe;
   logic [3:0] outs;
   logic       connected;
   logic [8:0] vec;
   logic [8:0] last;
   logic [8:0] notes[$];
   int         num_errors;
   int         check_count;
   int         seed;
   int         i;
   int         n;
   int         len;

   hsr_top u_dut (
      .REF_CLK                     (clk),
      .ARST_N                      (arst_n),
      .VCCA_GOOD                   (vcca),
      .VCCB_GOOD                   (vccb),
      .EN_PIN                      (en_pin),
      .LOW_SIDE_CLOCK_LINE_IN      (a_in[0]),
      .LOW_SIDE_CLOCK_LINE_OUT     (outs[0]),
      .LOW_SIDE_CLOCK_LINE_OE      (a_oe[0]),
      .LOW_SIDE_DATA_LINE_IN       (a_in[1]),
      .LOW_SIDE_DATA_LINE_OUT      (outs[1]),
      .LOW_SIDE_DATA_LINE_OE       (a_oe[1]),
      .HIGH_SIDE_CLOCK_LINE_IN     (b_in[0]),
      .HIGH_SIDE_CLOCK_LINE_MID_IN (b_mid[0]),
      .HIGH_SIDE_CLOCK_LINE_OUT    (outs[2]),
      .HIGH_SIDE_CLOCK_LINE_OE     (b_oe[0]),
      .HIGH_SIDE_DATA_LINE_IN      (b_in[1]),
      .HIGH_SIDE_DATA_LINE_MID_IN  (b_mid[1]),
      .HIGH_SIDE_DATA_LINE_OUT     (outs[3]),
      .HIGH_SIDE_DATA_LINE_OE      (b_oe[1]),
      .CONNECTED                   (connected)
   );

   hsr_bus_model u_bus (
      .a_oe         (a_oe),
      .b_oe         (b_oe),
      .ext_a_low    (ext_a),
      .ext_b_strong (ext_bs),
      .ext_b_weak   (ext_bw),
      .en_drive     (en_drive),
      .en_level     (en_level),
      .a_in         (a_in),
      .b_in         (b_in),
      .b_mid        (b_mid),
      .en_pin       (en_pin)
   );

   // Note layout: connected, A clock, A data, B clock, B data, then the four OUTs
   assign vec = {connected, a_oe[0], a_oe[1], b_oe[0], b_oe[1], outs};

   always #10 clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic note(input logic [4:0] e);
      notes.push_back({e, 4'h0});
   endtask

   // Every noted change must appear, and not sooner than lo cycles
   task automatic wait_drain(input int lo, input int hi);
      int w;
      w = 0;
      while (notes.size() != 0 && w <= hi) begin
         tick(1);
         w++;
      end
      check(32'(w >= lo), 32'h1);
      if (notes.size() != 0) begin
         check(w, hi);
         results();
      end
   endtask

   // Any output change with no note pending is itself a mismatch
   always @(negedge clk) begin
      if (vec !== last) begin
         if (notes.size() == 0) begin
            check(vec, last);
         end else begin
            check(vec, notes.pop_front());
         end
      end
      last = vec;
   end

   initial begin
      clk         = 1'b0;
      arst_n      = 1'b0;
      vcca        = 1'b0;
      vccb        = 1'b0;
      en_drive    = 1'b0;
      en_level    = 1'b0;
      ext_a       = 2'b00;
      ext_bs      = 2'b00;
      ext_bw      = 2'b00;
      last        = 9'h000;
      num_errors  = 0;
      check_count = 0;
      seed        = 32'h6BD2;
      tick(20);
      arst_n = 1'b1;
      // Half powered: activity on both sides must not move any driver
      tick(20);
      vcca   = 1'b1;
      ext_a  = 2'b11;
      ext_bs = 2'b11;
      tick(30);
      ext_a  = 2'b00;
      ext_bs = 2'b00;
      tick(30);
      note(5'h10);
      vccb = 1'b1;
      wait_drain(INIT_CYC + IDLE_CYC, INIT_CYC + IDLE_CYC + 30);
      for (i = 0; i < 2; i++) begin
         note(5'h10 | (5'h02 >> i));
         ext_a[i] = 1'b1;
         wait_drain(2, 8);
         note(5'h10);
         ext_a[i] = 1'b0;
         wait_drain(2, 8);
         note(5'h10 | (5'h08 >> i) | (5'h02 >> i));
         ext_bs[i] = 1'b1;
         wait_drain(2, 8);
         note(5'h10 | (5'h02 >> i));
         note(5'h10);
         ext_bs[i] = 1'b0;
         wait_drain(2, 16);
         // Weak LOW: A pulled briefly, B held until A is back up
         note(5'h10 | (5'h08 >> i) | (5'h02 >> i));
         note(5'h10 | (5'h02 >> i));
         note(5'h10);
         ext_bw[i] = 1'b1;
         for (n = 0; n < 10 && notes.size() == 3; n++) begin
            tick(1);
         end
         ext_bw[i] = 1'b0;
         wait_drain(0, 20);
      end
      // Random A-side pulses, short ones included
      repeat (24) begin
         i   = $random(seed) & 1;
         len = 3 + ($random(seed) & 15);
         note(5'h10 | (5'h02 >> i));
         note(5'h10);
         ext_a[i] = 1'b1;
         tick(len);
         ext_a[i] = 1'b0;
         wait_drain(0, 12);
         tick($random(seed) & 7);
      end
      // Disable on an idle bus, then traffic must stay unseen
      note(5'h00);
      en_drive = 1'b1;
      wait_drain(1, 8);
      ext_a  = 2'b11;
      ext_bs = 2'b11;
      tick(20);
      ext_a  = 2'b00;
      ext_bs = 2'b00;
      tick(10);
      // Released pin floats HIGH; bus gets busy before the settle time ends
      en_drive = 1'b0;
      tick(5);
      ext_a[1] = 1'b1;
      tick(INIT_CYC + 150);
      note(5'h10);
      ext_a[1] = 1'b0;
      wait_drain(0, 12);
      // Supply drop with a line held low releases everything at once
      ext_a[0] = 1'b1;
      note(5'h12);
      wait_drain(2, 8);
      note(5'h00);
      vcca = 1'b0;
      wait_drain(1, 6);
      ext_a[0] = 1'b0;
      tick(5);
      vccb = 1'b0;
      tick(5);
      vccb = 1'b1;
      tick(100);
      note(5'h10);
      vcca = 1'b1;
      wait_drain(INIT_CYC + IDLE_CYC, INIT_CYC + IDLE_CYC + 30);
      tick(20);
      results();
   end
endmodule // hsr_top_tb
